// ==== logic/uhts_pkg.sv ====
// Constants shared by the host transfer setup block.
`default_nettype none
package uhts_pkg;

  // ----------------------------------------------------------------------
  // Register offsets inside the host register space.
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A   = 8'h00;  // Transfer control, set A.
  localparam logic [7:0] OFS_PTR_A    = 8'h01;  // Buffer pointer, set A.
  localparam logic [7:0] OFS_CTRL_B   = 8'h08;  // Transfer control, set B.
  localparam logic [7:0] OFS_PTR_B    = 8'h09;  // Buffer pointer, set B.
  localparam logic [7:0] OFS_CTRL2    = 8'h0F;  // Control register 2, enables set B.

  // ----------------------------------------------------------------------
  // Transfer control field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_PREAMBLE = 7;  // Preamble ahead of a low speed packet.
  localparam int BIT_TOGGLE   = 6;  // DATA0 when 0, DATA1 when 1.
  localparam int BIT_SOF_WAIT = 5;  // frame_start_wait: hold until after SOF.
  localparam int BIT_ISO      = 4;  // Isochronous, no handshake phase.
  localparam int BIT_RSVD     = 3;  // Reserved, no function.
  localparam int BIT_DIR      = 2;  // 1 is OUT, 0 is IN.
  localparam int BIT_ENABLE   = 1;  // Transfers allowed.
  localparam int BIT_ARM      = 0;  // Armed, cleared at completion.

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;  // Arm must be zero; rest cleared too.
  localparam logic [7:0] RST_PTR  = 8'h00;  // Pointer reset value.

  // Scheduler states, Gray coded along idle, wait for SOF, running.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SOF  = 2'b01,
    ST_RUN  = 2'b11
  } uhts_state_e;

endpackage : uhts_pkg
`default_nettype wire

// ==== logic/uhts_top.sv ====
// Host transfer setup: register sets A and B, bus port and transfer launcher.
`timescale 1ns/1ps
`default_nettype none

module uhts_top (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Processor bus pins, asynchronous to clk.
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       a0,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic       data_oe,
  // Line mode from control registers 1 and 2, same clock.
  input  wire logic       low_speed_sel,
  input  wire logic       low_speed_pol,
  // Serial engine status, same clock.
  input  wire logic       engine_busy,
  input  wire logic       sof_sent,
  input  wire logic       xfer_done,
  // Transfer request toward the serial engine, then the completion pulse and completed set.
  output var  logic       xfer_start,
  output var  logic       xfer_set,
  output var  logic       xfer_preamble,
  output var  logic       xfer_toggle,
  output var  logic       xfer_iso,
  output var  logic       xfer_out,
  output var  logic [7:0] xfer_ptr,
  output var  logic       done_pulse,
  output var  logic       done_set
);

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic [11:0] pin_s1_q;   // First stage, read only by the second stage.
  logic [11:0] pin_s2_q;   // Second stage, safe to use.
  logic        wr_prev_q;  // Last synced write strobe, for edge detection.
  logic        rd_prev_q;  // Last synced read strobe, for edge detection.

  // Two flops on every bus pin; data is wide but only sampled after the
  // strobe edge, by which time it has been stable for two cycles.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q  <= 12'hF00;
      pin_s2_q  <= 12'hF00;
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
    end else begin
      pin_s1_q  <= {cs_n, rd_n, wr_n, a0, data_in};
      pin_s2_q  <= pin_s1_q;
      wr_prev_q <= pin_s2_q[9];
      rd_prev_q <= pin_s2_q[10];
    end
  end

  logic       s_cs_n;   // Synced chip select.
  logic       s_rd_n;   // Synced read strobe.
  logic       s_wr_n;   // Synced write strobe.
  logic       s_a0;     // Synced address line.
  logic [7:0] s_data;   // Synced data bus.
  logic       wr_evt;   // One-cycle pulse at write strobe release.
  logic       rd_evt;   // One-cycle pulse at read strobe assertion.

  // A write is taken on the rising edge of the strobe, when data is settled.
  always_comb begin
    s_cs_n = pin_s2_q[11];
    s_rd_n = pin_s2_q[10];
    s_wr_n = pin_s2_q[9];
    s_a0   = pin_s2_q[8];
    s_data = pin_s2_q[7:0];
    wr_evt = !s_cs_n && s_wr_n && !wr_prev_q;
    rd_evt = !s_cs_n && !s_rd_n && rd_prev_q;
  end

  // ----------------------------------------------------------------------
  // Address pointer and register sets.
  // ----------------------------------------------------------------------
  logic [7:0] addr_q, addr_d;          // Address from the A0 low cycle.
  logic [7:0] ctrl_q [2];              // Transfer control per set.
  logic [7:0] ctrl_d [2];
  logic [7:0] ptr_q  [2];              // Buffer pointer per set.
  logic [7:0] ptr_d  [2];
  logic       ext_q, ext_d;            // Extended mode, allows set B.
  logic [7:0] rdat_q, rdat_d;          // Read data returned to the bus.
  logic       oe_q, oe_d;              // Bus driven during a mapped read.
  logic       clr_arm [2];             // Completion clear of arm per set.

  // Decodes which set a control or pointer offset belongs to.
  function automatic logic [2:0] dec_addr(input logic [7:0] adr);
    // Result bits: hit control, hit pointer, set index.
    logic [2:0] r;
    r = 3'h0;
    if (adr == uhts_pkg::OFS_CTRL_A) r = 3'h4;
    if (adr == uhts_pkg::OFS_PTR_A)  r = 3'h2;
    if (adr == uhts_pkg::OFS_CTRL_B) r = 3'h5;
    if (adr == uhts_pkg::OFS_PTR_B)  r = 3'h3;
    return r;
  endfunction : dec_addr

  // Register next values. A software write wins over the completion clear,
  // so a re-arm that lands in the done cycle is never lost.
  always_comb begin
    logic [2:0] hit;
    hit    = dec_addr(addr_q);
    addr_d = addr_q;
    ext_d  = ext_q;
    rdat_d = rdat_q;
    oe_d   = oe_q && !s_cs_n && !s_rd_n;
    for (int i = 0; i < 2; i++) begin
      ctrl_d[i] = ctrl_q[i];
      ptr_d[i]  = ptr_q[i];
      if (clr_arm[i]) begin
        ctrl_d[i][uhts_pkg::BIT_ARM] = 1'b0;
      end
    end
    if (wr_evt && !s_a0) begin
      addr_d = s_data;
    end else if (wr_evt) begin
      if (addr_q == uhts_pkg::OFS_CTRL2) begin
        ext_d = 1'b1;
      end
      if (hit[2]) begin
        ctrl_d[hit[0]] = s_data;
        ctrl_d[hit[0]][uhts_pkg::BIT_RSVD] = 1'b0;
      end
      if (hit[1]) begin
        ptr_d[hit[0]] = s_data;
      end
    end
    if (rd_evt && s_a0 && (hit[2] || hit[1])) begin
      rdat_d = hit[2] ? ctrl_q[hit[0]] : ptr_q[hit[0]];
      oe_d   = 1'b1;
    end
  end

  // Register storage; only arm and extended mode need a reset, the rest is
  // cleared as well so that simulation never sees unknown setups.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q    <= 8'h00;
      ext_q     <= 1'b0;
      rdat_q    <= 8'h00;
      oe_q      <= 1'b0;
      ctrl_q[0] <= uhts_pkg::RST_CTRL;
      ctrl_q[1] <= uhts_pkg::RST_CTRL;
      ptr_q[0]  <= uhts_pkg::RST_PTR;
      ptr_q[1]  <= uhts_pkg::RST_PTR;
    end else begin
      addr_q    <= addr_d;
      ext_q     <= ext_d;
      rdat_q    <= rdat_d;
      oe_q      <= oe_d;
      ctrl_q    <= ctrl_d;
      ptr_q     <= ptr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus outputs.
  // ----------------------------------------------------------------------
  // Both come straight from registers, so the pads never see decode glitches;
  // the cost is one cycle of read latency, hidden behind the strobe timing.
  assign data_out = rdat_q;
  assign data_oe  = oe_q;

  // ----------------------------------------------------------------------
  // Transfer scheduler.
  // ----------------------------------------------------------------------
  uhts_pkg::uhts_state_e st_q, st_d;   // Scheduler state.
  logic       pref_q, pref_d;          // Set tried first next time.
  logic       cur_q, cur_d;            // Set owning the current transfer.
  logic       ready [2];               // Set enabled, armed and usable.
  logic       pick;                    // Set chosen from idle.
  logic       any_ready;               // Some set may launch.
  logic       direct_ls;               // Direct low speed line mode.
  logic       start_d, pre_d, tog_d, iso_d, out_d, dpl_d;
  logic [7:0] ptrx_d;

  // Launch decision. A snapshot of the set is taken at launch and held for
  // the whole transaction, so late writes cannot disturb the engine.
  always_comb begin
    direct_ls = low_speed_sel && low_speed_pol;
    for (int i = 0; i < 2; i++) begin
      ready[i] = ctrl_q[i][uhts_pkg::BIT_ENABLE] &&
                 ctrl_q[i][uhts_pkg::BIT_ARM] && ((i == 0) || ext_q);
    end
    pick      = ready[pref_q] ? pref_q : !pref_q;
    any_ready = ready[0] || ready[1];
    st_d    = st_q;
    pref_d  = pref_q;
    cur_d   = cur_q;
    start_d = 1'b0;
    dpl_d   = 1'b0;
    clr_arm[0] = 1'b0;
    clr_arm[1] = 1'b0;
    case (st_q)
      uhts_pkg::ST_IDLE: begin
        if (any_ready) begin
          cur_d = pick;
          // Sync is honoured only at full speed.
          if (ctrl_q[pick][uhts_pkg::BIT_SOF_WAIT] && !low_speed_sel) begin
            st_d = uhts_pkg::ST_SOF;
          end else if (!engine_busy) begin
            st_d    = uhts_pkg::ST_RUN;
            start_d = 1'b1;
          end
        end
      end
      uhts_pkg::ST_SOF: begin
        if (!ready[cur_q]) begin
          st_d = uhts_pkg::ST_IDLE;
        end else if (sof_sent) begin
          st_d    = uhts_pkg::ST_RUN;
          start_d = 1'b1;
        end
      end
      uhts_pkg::ST_RUN: begin
        if (xfer_done) begin
          st_d           = uhts_pkg::ST_IDLE;
          clr_arm[cur_q] = 1'b1;
          dpl_d          = 1'b1;
          pref_d         = !cur_q;
        end
      end
      default: begin
        st_d = uhts_pkg::ST_IDLE;
      end
    endcase
    pre_d  = ctrl_q[cur_d][uhts_pkg::BIT_PREAMBLE] && !direct_ls;
    out_d  = ctrl_q[cur_d][uhts_pkg::BIT_DIR];
    tog_d  = ctrl_q[cur_d][uhts_pkg::BIT_TOGGLE] && out_d;
    iso_d  = ctrl_q[cur_d][uhts_pkg::BIT_ISO];
    ptrx_d = ptr_q[cur_d];
  end

  // Scheduler registers; transfer fields only load at launch.
  // The completed set is only updated with the done pulse, so it stays valid
  // until the next completion for whoever reads it later.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q          <= uhts_pkg::ST_IDLE;
      pref_q        <= 1'b0;
      cur_q         <= 1'b0;
      xfer_start    <= 1'b0;
      xfer_set      <= 1'b0;
      xfer_preamble <= 1'b0;
      xfer_toggle   <= 1'b0;
      xfer_iso      <= 1'b0;
      xfer_out      <= 1'b0;
      xfer_ptr      <= 8'h00;
      done_pulse    <= 1'b0;
      done_set      <= 1'b0;
    end else begin
      st_q       <= st_d;
      pref_q     <= pref_d;
      cur_q      <= cur_d;
      xfer_start <= start_d;
      done_pulse <= dpl_d;
      if (dpl_d) begin
        done_set <= cur_q;
      end
      if (start_d) begin
        xfer_set      <= cur_d;
        xfer_preamble <= pre_d;
        xfer_toggle   <= tog_d;
        xfer_iso      <= iso_d;
        xfer_out      <= out_d;
        xfer_ptr      <= ptrx_d;
      end
    end
  end

endmodule : uhts_top
`default_nettype wire

// ==== tb/uhts_top_asserts.sv ====
// Concurrent checks on the launch and completion ports of the transfer setup block.
`timescale 1ns/1ps
`default_nettype none
module uhts_top_asserts (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Line mode and engine status.
  input wire logic       low_speed_sel,
  input wire logic       low_speed_pol,
  input wire logic       engine_busy,
  input wire logic       xfer_done,
  // Launch and completion.
  input wire logic       xfer_start,
  input wire logic       xfer_set,
  input wire logic       xfer_preamble,
  input wire logic       xfer_toggle,
  input wire logic       xfer_iso,
  input wire logic       xfer_out,
  input wire logic [7:0] xfer_ptr,
  input wire logic       done_pulse,
  input wire logic       done_set
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A transfer is open from its launch until its completion pulse.
  logic open_q;
  logic open_d;
  always_comb begin
    open_d = xfer_start | (open_q & ~done_pulse);
  end
  always_ff @(posedge clk) begin
    open_q <= sys_rst ? 1'b0 : open_d;
  end
  // A launch is a single cycle; completion follows the engine one cycle later.
  sequence s_start_pulse;
    xfer_start ##1 !xfer_start;
  endsequence
  sequence s_finish;
    xfer_done ##1 done_pulse;
  endsequence
  AST_START_PULSE: assert property (xfer_start |-> s_start_pulse)
    else $error("launch pulse is not one cycle");
  AST_DONE_FOLLOWS: assert property (xfer_done |-> s_finish)
    else $error("completion pulse missing after engine done");
  AST_DONE_SET: assert property (done_pulse |-> done_set == xfer_set)
    else $error("completed set differs from launched set");
  AST_TOGGLE_IN: assert property (xfer_start && !xfer_out |-> !xfer_toggle)
    else $error("toggle driven on an IN launch");
  AST_PREAMBLE_DIRECT: assert property (xfer_start && low_speed_sel && low_speed_pol |->
    !xfer_preamble)
    else $error("preamble in direct low speed mode");
  AST_ENGINE_FREE: assert property (xfer_start |-> $past(engine_busy) == 1'b0)
    else $error("launch while engine busy");
  AST_ONE_AT_TIME: assert property (xfer_start |-> !open_q || done_pulse)
    else $error("second launch before completion");
  AST_FIELDS_HOLD: assert property (!xfer_start |->
    $stable({xfer_set, xfer_preamble, xfer_toggle, xfer_iso, xfer_out, xfer_ptr}))
    else $error("launch fields changed without a launch");
endmodule : uhts_top_asserts
bind uhts_top uhts_top_asserts u_chk (.clk, .sys_rst, .low_speed_sel, .low_speed_pol,
  .engine_busy, .xfer_done, .xfer_start, .xfer_set, .xfer_preamble, .xfer_toggle,
  .xfer_iso, .xfer_out, .xfer_ptr, .done_pulse, .done_set);
`default_nettype wire

// ==== tb/uhts_engine_model.sv ====
// Serial engine stand-in: busy for each launch, a done pulse, periodic frame starts.
`timescale 1ns/1ps
`default_nettype none
module uhts_engine_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Launch from the block.
  input  wire logic xfer_start,
  // Status back to the block.
  output var  logic engine_busy,
  output var  logic sof_sent,
  output var  logic xfer_done
);
  logic [4:0] left_q;  // Cycles left in the running transfer.
  logic [5:0] frm_q;   // Frame timer, one frame start every 64 cycles.
  logic       run_q;   // A launched transfer is in progress.
  // Transfer length follows the frame timer, so replies come both fast and slow.
  // The engine is also busy while a frame start goes out, so an immediate
  // launch must sometimes wait; it is free again when sof_sent pulses.
  always_ff @(posedge clk) begin
    frm_q       <= sys_rst ? 6'h00 : frm_q + 6'h01;
    sof_sent    <= !sys_rst && frm_q == 6'h3F;
    run_q       <= !sys_rst && (xfer_start || (run_q && left_q != 5'h01));
    engine_busy <= !sys_rst && (xfer_start || (run_q && left_q != 5'h01) ||
                   (frm_q >= 6'h3C && frm_q != 6'h3F));
    xfer_done   <= !sys_rst && run_q && left_q == 5'h01;
    left_q      <= xfer_start ? 5'h02 + {1'b0, frm_q[3:0]} : left_q - 5'h01;
  end
endmodule : uhts_engine_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the host transfer setup block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, sys_rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, a0 = 1'b0;
  logic        low_speed_sel = 1'b0, low_speed_pol = 1'b0, oe, st_sof, last_set;
  logic [7:0]  data_in = 8'h00, data_out, xfer_ptr, q;
  logic        data_oe, engine_busy, sof_sent, xfer_done, xfer_start, xfer_set;
  logic        xfer_preamble, xfer_toggle, xfer_iso, xfer_out, done_pulse, done_set;
  logic [12:0] st_q;         // Fields of the latest launch.
  logic [2:0]  sof_h = 3'h0; // Recent frame start pulses.
  logic [7:0]  corner [4] = '{8'hFF, 8'h63, 8'h2B, 8'h87};
  int          n_start = 0, n_done = 0, n_mismatch = 0, n_tests = 0, cyc = 0, seed = 77;
  uhts_top dut (.clk, .sys_rst, .cs_n, .rd_n, .wr_n, .a0, .data_in, .data_out, .data_oe,
    .low_speed_sel, .low_speed_pol, .engine_busy, .sof_sent, .xfer_done, .xfer_start,
    .xfer_set, .xfer_preamble, .xfer_toggle, .xfer_iso, .xfer_out, .xfer_ptr,
    .done_pulse, .done_set);
  uhts_engine_model u_eng (.clk, .sys_rst, .xfer_start, .engine_busy, .sof_sent, .xfer_done);
  initial forever #2 clk = ~clk;
  // Record launches and completions; a hang ends the run as a failure.
  always @(posedge clk) begin
    if (xfer_start === 1'b1) begin
      st_q = {xfer_set, xfer_preamble, xfer_toggle, xfer_iso, xfer_out, xfer_ptr};
      st_sof = |sof_h;
      n_start++;
    end
    n_done = n_done + (done_pulse === 1'b1 ? 1 : 0);
    if (done_pulse === 1'b1) begin
      last_set = done_set;
    end
    sof_h = {sof_h[1:0], sof_sent};
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask : chk
  // One pin cycle; strobes stay five cycles low and high to clear the synchronisers.
  task automatic pin(input logic a, input logic [7:0] d, input logic rd);
    @(negedge clk);
    a0 = a;
    data_in = d;
    cs_n = 1'b0;
    rd_n = ~rd;
    wr_n = rd;
    repeat (5) @(negedge clk);
    q = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    data_in = ~d;
    @(negedge clk);
  endtask : pin
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    pin(1'b0, ad, 1'b0);
    pin(1'b1, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    pin(1'b0, ad, 1'b0);
    pin(1'b1, 8'h5A, 1'b1);
  endtask : rd
  // Launch fields that a set with this control byte and pointer must produce.
  function automatic logic [12:0] expect_launch(input logic s, input logic [7:0] c, p);
    return {s, c[7] & ~(low_speed_sel & low_speed_pol), c[6] & c[2], c[4], c[2], p};
  endfunction : expect_launch
  // Program a set, let it run, then compare launch, completion and readback.
  task automatic xfer(input logic s, input logic [7:0] c, input logic [7:0] p);
    int d0;
    d0 = n_done;
    wr({4'h0, s, 3'h1}, p);
    wr({4'h0, s, 3'h0}, c);
    for (int i = 0; i < 300 && n_done == d0; i++) @(negedge clk);
    chk("done", 13'(n_done - d0), 13'h1);
    chk("done_set", {12'h0, last_set}, {12'h0, s});
    chk("launch", st_q, expect_launch(s, c, p));
    chk("sync", {12'h0, st_sof | ~c[5]}, 13'h1);
    rd({4'h0, s, 3'h0});
    chk("ctrl", {5'h0, q}, {5'h0, c & 8'hF6});
    chk("ctrl_oe", {12'h0, oe}, 13'h1);
  endtask : xfer
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    int         d0;
    logic [7:0] c;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    rd(8'h00);
    chk("arm_a", {12'h0, q[0]}, 13'h0);
    rd(8'h03);
    chk("unmapped_oe", {12'h0, oe}, 13'h0);
    // Armed but disabled, then set B before the extended mode write.
    wr(8'h00, 8'h05);
    wr(8'h08, 8'h03);
    repeat (60) @(negedge clk);
    chk("quiet", 13'(n_start), 13'h0);
    wr(8'h0F, 8'h00);
    repeat (60) @(negedge clk);
    chk("b_open", st_q, expect_launch(1'b1, 8'h03, 8'h00));
    // Both sets armed back to back run one after the other.
    d0 = n_done;
    wr(8'h00, 8'h07);
    wr(8'h08, 8'h07);
    repeat (80) @(negedge clk);
    chk("overlap", {8'(n_done - d0), st_q[12:8]}, {8'h02, 5'b10001});
    $display("directed tests done");
    // Corner control bytes first, then random setups on alternating sets.
    for (int k = 0; k < 12; k++) begin
      {low_speed_sel, low_speed_pol} = k < 4 ? 2'(k) : 2'($random(seed));
      c = k < 4 ? corner[k] : 8'($random(seed));
      xfer(k[0], {c[7], k[0], c[5] & ~low_speed_sel, c[4:2], 2'h3}, 8'($random(seed)));
      $display("test %0d done", k);
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
